/* irq_ctrl_pkg.sv */
/*
 * constants for the interrupt controller: register offsets, field
 * positions, reset values, edge codes and vector layout.
 * assumes an 8-bit apb address space with one 32-bit word per register.
 */
package irq_ctrl_pkg;
    localparam int NGRP = 6;
    localparam int NPIN = 4;
    localparam int NSRC = NPIN + NGRP;
    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFF_GRP0 = 8'h00;
    localparam logic [7:0] OFF_STEP = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_FLAG = 8'h1C;
    localparam logic [7:0] OFF_EDGE = 8'h20;
    localparam logic [7:0] OFF_STAT = 8'h24;

    // reset value of every register
    localparam logic [7:0] RST_BYTE = 8'h00;

    // implemented bits per group register, group 5 first
    localparam logic [NGRP-1:0][7:0] GRP_MASK = {
        8'h33, 8'hFF, 8'hFF, 8'h33, 8'hFF, 8'hFF
    };

    // field positions
    localparam int FLG_LSB = 4;
    localparam int CTRL_EMI = 0;
    localparam int CTRL_PIN_EN = 4;
    localparam int CTRL_GRP_EN = 8;
    localparam int FLAG_PIN = 0;
    localparam int FLAG_GRP = 8;
    localparam int STAT_SFULL = 0;
    localparam int STAT_WAKE = 1;
    localparam int STAT_LAST = 4;

    // edge select codes
    localparam logic [1:0] EDGE_OFF = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    // vector table: base plus index times step
    localparam int VEC_BASE = 4;
    localparam int VEC_STEP = 4;
endpackage

/* irq_ctrl.sv */
/*
 * interrupt controller: six grouped request registers, four edge pins,
 * global and individual enables, fixed priority, pc push and vectoring.
 * assumes an apb master, a core giving an instruction boundary strobe,
 * the next pc and a stack-full level, and single-cycle source pulses.
 */
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module irq_ctrl #(
    parameter int PC_W = 13
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [4*irq_ctrl_pkg::NGRP-1:0] src_evt_i,
    input wire logic [irq_ctrl_pkg::NPIN-1:0] pin_i,
    input wire logic [irq_ctrl_pkg::NPIN-1:0] pin_func_sel_i,
    input wire logic [irq_ctrl_pkg::NPIN-1:0] pin_dir_in_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic boundary_i,
    input wire logic stack_full_i,
    input wire logic return_from_interrupt_i,
    output logic call_o,
    output logic [PC_W-1:0] vector_o,
    output logic [PC_W-1:0] push_pc_o,
    output logic pop_o,
    output logic wake_o
);
    import irq_ctrl_pkg::*;

    typedef struct packed {
        logic [NGRP-1:0][7:0] grp_reg;
        logic global_irq_enable;
        logic [NPIN-1:0] pin_irq_enable;
        logic [NGRP-1:0] group_irq_enable;
        logic [NPIN-1:0] pin_irq_flag;
        logic [NGRP-1:0] group_irq_flag;
        logic [7:0] pin_edge_select_reg;
        logic [NPIN-1:0] sync1;
        logic [NPIN-1:0] sync2;
        logic [NPIN-1:0] sync3;
        logic [NPIN-1:0] pin_level;
        logic call;
        logic pop;
        logic [PC_W-1:0] vector;
        logic [PC_W-1:0] push_pc;
        logic [3:0] last_src;
        logic [31:0] rdata;
        logic err;
    } state_t;

    state_t s;
    state_t next_s;

    logic [NSRC-1:0] req;
    logic [NGRP-1:0] member_live;
    logic [NPIN-1:0] pin_ok;
    logic any_flag;

    // elaboration check: vector table must fit in the pc
    if (PC_W < 8 || PC_W > 16) begin : g_pc_w_check
        $error("irq_ctrl: PC_W must be 8 to 16");
    end

    // group request needs a member flag with its own enable
    for (genvar g = 0; g < NGRP; g++) begin : g_member
        assign member_live[g] = |(s.grp_reg[g][7:FLG_LSB] & s.grp_reg[g][FLG_LSB-1:0]);
    end

    // pin only serves as interrupt input when fully configured
    assign pin_ok = s.pin_irq_enable & pin_func_sel_i & pin_dir_in_i;

    // per-source vectoring request, gated by individual enables
    always_comb begin
        for (int p = 0; p < NPIN; p++) begin
            req[p] = s.pin_irq_flag[p] & s.pin_irq_enable[p]
                & (s.pin_edge_select_reg[2*p +: 2] != EDGE_OFF);
        end
        for (int g = 0; g < NGRP; g++) begin
            req[NPIN+g] = s.group_irq_flag[g] & s.group_irq_enable[g] & member_live[g];
        end
    end

    // any recorded flag, for wake-up
    always_comb begin
        any_flag = |s.pin_irq_flag | |s.group_irq_flag;
        for (int g = 0; g < NGRP; g++) begin
            any_flag = any_flag | |s.grp_reg[g][7:FLG_LSB];
        end
    end

    // next-state logic
    always_comb begin
        logic wr;
        logic take;
        logic [3:0] sel;
        logic [NGRP-1:0] grp_rise;
        logic [NPIN-1:0] agree;
        logic [NPIN-1:0] rise;
        logic [NPIN-1:0] fall;
        logic [NPIN-1:0] hit;
        logic [1:0] code;
        logic [7:0] a;
        logic [31:0] rd;
        logic bad;
        wr = 1'b0;
        take = 1'b0;
        sel = 4'h0;
        grp_rise = '0;
        agree = '0;
        rise = '0;
        fall = '0;
        hit = '0;
        code = EDGE_OFF;
        a = paddr_i;
        rd = 32'h0000_0000;
        bad = 1'b0;
        next_s = s;
        next_s.call = 1'b0;

        // return strobe pops the saved pc one cycle later
        next_s.pop = return_from_interrupt_i;

        // three-stage pin synchroniser, change taken once stages 2,3 agree
        next_s.sync1 = pin_i;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        agree = ~(s.sync2 ^ s.sync3);
        rise = agree & s.sync3 & ~s.pin_level;
        fall = agree & ~s.sync3 & s.pin_level;
        next_s.pin_level = (agree & s.sync3) | (~agree & s.pin_level);

        // apb register writes
        wr = psel_i & penable_i & pwrite_i;
        for (int g = 0; g < NGRP; g++) begin
            if (wr && a == OFF_GRP0 + 8'(g) * OFF_STEP) begin
                next_s.grp_reg[g] = pwdata_i[7:0] & GRP_MASK[g];
            end
        end
        if (wr && a == OFF_CTRL) begin
            next_s.global_irq_enable = pwdata_i[CTRL_EMI];
            next_s.pin_irq_enable = pwdata_i[CTRL_PIN_EN +: NPIN];
            next_s.group_irq_enable = pwdata_i[CTRL_GRP_EN +: NGRP];
        end
        if (wr && a == OFF_FLAG) begin
            next_s.pin_irq_flag = pwdata_i[FLAG_PIN +: NPIN];
            next_s.group_irq_flag = pwdata_i[FLAG_GRP +: NGRP];
        end
        if (wr && a == OFF_EDGE) begin
            next_s.pin_edge_select_reg = pwdata_i[7:0];
        end

        // fixed priority: lowest index wins, pins before groups
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                sel = 4'(i);
            end
        end
        take = s.global_irq_enable & |req & ~stack_full_i & boundary_i & ~s.call;

        // accept: push pc, load vector, block nesting, clear own flag
        if (take) begin
            next_s.call = 1'b1;
            next_s.push_pc = pc_i;
            next_s.vector = PC_W'(VEC_BASE + VEC_STEP * int'(sel));
            next_s.last_src = sel;
            next_s.global_irq_enable = 1'b0;
            if (sel < 4'(NPIN)) begin
                next_s.pin_irq_flag[sel[1:0]] = 1'b0;
            end else begin
                next_s.group_irq_flag[3'(sel - 4'(NPIN))] = 1'b0;
            end
        end

        // source events set member flags whatever the enables
        for (int g = 0; g < NGRP; g++) begin
            next_s.grp_reg[g][7:FLG_LSB] = next_s.grp_reg[g][7:FLG_LSB]
                | (src_evt_i[4*g +: 4] & GRP_MASK[g][7:FLG_LSB]);
            grp_rise[g] = |(next_s.grp_reg[g][7:FLG_LSB] & ~s.grp_reg[g][7:FLG_LSB]);
        end
        // member flag rising sets its group flag, over any clear
        next_s.group_irq_flag = next_s.group_irq_flag | grp_rise;

        // pin edge detection per selected edge code
        for (int p = 0; p < NPIN; p++) begin
            code = s.pin_edge_select_reg[2*p +: 2];
            case (code)
                EDGE_RISE: hit[p] = rise[p];
                EDGE_FALL: hit[p] = fall[p];
                EDGE_BOTH: hit[p] = rise[p] | fall[p];
                default: hit[p] = 1'b0;
            endcase
        end
        next_s.pin_irq_flag = next_s.pin_irq_flag | (hit & pin_ok);

        // read mux, captured in the setup phase
        for (int g = 0; g < NGRP; g++) begin
            if (a == OFF_GRP0 + 8'(g) * OFF_STEP) begin
                rd = {24'h00_0000, s.grp_reg[g] & GRP_MASK[g]};
            end
        end
        case (a)
            OFF_CTRL: begin
                rd[CTRL_EMI] = s.global_irq_enable;
                rd[CTRL_PIN_EN +: NPIN] = s.pin_irq_enable;
                rd[CTRL_GRP_EN +: NGRP] = s.group_irq_enable;
            end
            OFF_FLAG: begin
                rd[FLAG_PIN +: NPIN] = s.pin_irq_flag;
                rd[FLAG_GRP +: NGRP] = s.group_irq_flag;
            end
            OFF_EDGE: rd[7:0] = s.pin_edge_select_reg;
            OFF_STAT: begin
                rd[STAT_SFULL] = stack_full_i;
                rd[STAT_WAKE] = any_flag;
                rd[STAT_LAST +: 4] = s.last_src;
            end
            default: begin
                bad = (a > OFF_GRP0 + 8'(NGRP - 1) * OFF_STEP) || (a[1:0] != 2'b00);
            end
        endcase
        if (psel_i && !penable_i) begin
            next_s.rdata = bad ? 32'h0000_0000 : rd;
            next_s.err = bad;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // outputs
    assign prdata_o = s.rdata;
    assign pready_o = 1'b1;
    assign pslverr_o = s.err & psel_i & penable_i;
    assign call_o = s.call;
    assign vector_o = s.vector;
    assign push_pc_o = s.push_pc;
    assign pop_o = s.pop;
    assign wake_o = any_flag;
endmodule

/* irq_ctrl_monitor.sv */
/* checker: accept, return, vector and wake timing at the ports.
   assumes it is bound into every irq_ctrl instance. */
`timescale 1ns/1ns
module irq_ctrl_monitor #(
    parameter int PC_W = 13
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [irq_ctrl_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [4*irq_ctrl_pkg::NGRP-1:0] src_evt_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic boundary_i,
    input wire logic stack_full_i,
    input wire logic return_from_interrupt_i,
    input wire logic call_o,
    input wire logic [PC_W-1:0] vector_o,
    input wire logic [PC_W-1:0] push_pc_o,
    input wire logic pop_o,
    input wire logic wake_o
);
    import irq_ctrl_pkg::*;
    logic emi_wr;
    // software re-arming the global enable, which legally allows an early next accept
    assign emi_wr = psel_i && penable_i && pwrite_i && paddr_i == OFF_CTRL && pwdata_i[CTRL_EMI];
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // return strobe, and the gap that must follow an accept
    sequence ret_s;
        return_from_interrupt_i ##1 pop_o;
    endsequence
    sequence quiet_s;
        !call_o [*2];
    endsequence
    a_call_gap: assert property (call_o && !emi_wr |=> quiet_s) else $error("call repeated");
    a_ret_pop: assert property (return_from_interrupt_i |-> ret_s) else $error("no pop");
    a_pop_cause: assert property (pop_o |-> $past(return_from_interrupt_i)) else $error("stray pop");
    a_call_cause: assert property (call_o |-> $past(boundary_i) && !$past(stack_full_i))
        else $error("bad accept");
    a_vec_range: assert property (call_o |-> vector_o[1:0] == 2'b00 && vector_o inside {[4:40]})
        else $error("bad vector");
    a_push_pc: assert property (call_o |-> push_pc_o == $past(pc_i)) else $error("bad pc");
    a_vec_hold: assert property (!call_o |-> $stable(vector_o) && $stable(push_pc_o))
        else $error("vector moved");
    a_wake_evt: assert property (|(src_evt_i & 24'h3F_F3FF) |=> wake_o) else $error("no wake");
endmodule
bind irq_ctrl irq_ctrl_monitor #(.PC_W(PC_W)) mon_u (.clk_i, .rstn_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .src_evt_i, .pc_i,
    .boundary_i, .stack_full_i, .return_from_interrupt_i, .call_o, .vector_o, .push_pc_o, .pop_o, .wake_o);

/* irq_core_model.sv */
/* core and stack model: running pc, boundary strobe, stack of pushed pcs.
   assumes the bench commands full stack, slow boundary and returns. */
`timescale 1ns/1ns
module irq_core_model #(
    parameter int PC_W = 13
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic full_i,
    input wire logic slow_i,
    input wire logic ret_i,
    input wire logic call_i,
    input wire logic [PC_W-1:0] push_pc_i,
    input wire logic pop_i,
    output logic [PC_W-1:0] pc_o,
    output logic boundary_o,
    output logic stack_full_o,
    output logic return_from_interrupt_o,
    output logic [PC_W-1:0] resume_o
);
    logic [PC_W-1:0] stack_q[$];
    logic tick;
    // slow mode offers a boundary every other cycle only
    assign boundary_o = !slow_i || tick;
    assign stack_full_o = full_i;
    // pc runs on, accepts push, returns pop
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_o <= PC_W'(16);
            tick <= 1'b0;
            return_from_interrupt_o <= 1'b0;
            resume_o <= '0;
        end else begin
            pc_o <= pc_o + 1'b1;
            tick <= !tick;
            return_from_interrupt_o <= ret_i && stack_q.size() > 0;
            if (call_i) stack_q.push_back(push_pc_i);
            if (pop_i) resume_o <= stack_q.pop_back();
        end
    end
endmodule

/* irq_ctrl_tb.sv */
/* bench for irq_ctrl: registers, events, service, priority, return, pin edges.
   assumes the core model on the far side. */
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module irq_ctrl_tb;
    import irq_ctrl_pkg::*;
    logic clk_i = 0, rstn_i = 0, psel = 0, penable = 0, pwrite = 0, er, pready, pslverr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [23:0] src = 0;
    logic [3:0] pin = 0, fsel = 4'hF, dir = 4'hF;
    logic [12:0] pc, vec, ppc, resume, prev_pc, got, vec_q[$], pc_q[$];
    logic bnd, sfull, return_from_interrupt, call, pop, wake, full = 1, slow = 0, ret = 0;
    int fails = 0, num_checks = 0, ncall = 0, cyc = 0, g, b, h, p, n;
    always #20 clk_i = !clk_i;
    irq_ctrl dut_u (.clk_i, .rstn_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .src_evt_i(src), .pin_i(pin), .pin_func_sel_i(fsel),
        .pin_dir_in_i(dir), .pc_i(pc), .boundary_i(bnd), .stack_full_i(sfull), .return_from_interrupt_i(return_from_interrupt),
        .call_o(call), .vector_o(vec), .push_pc_o(ppc), .pop_o(pop), .wake_o(wake));
    irq_core_model core_u (.clk_i, .rstn_i, .full_i(full), .slow_i(slow), .ret_i(ret),
        .call_i(call), .push_pc_i(ppc), .pop_i(pop), .pc_o(pc), .boundary_o(bnd),
        .stack_full_o(sfull), .return_from_interrupt_o(return_from_interrupt), .resume_o(resume));
    // record accepts with the pc they saved, and cut a hang short
    always @(posedge clk_i) begin
        prev_pc <= pc;
        cyc++;
        if (call) begin
            ncall++;
            vec_q.push_back(vec);
            pc_q.push_back(prev_pc);
        end
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1;
        @(posedge clk_i);
        while (pready !== 1'b1) @(posedge clk_i);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        `CHK(rd, e)
    endtask
    task automatic pulse(input int i);
        @(posedge clk_i);
        src <= 24'h1 << i;
        @(posedge clk_i);
        src <= 0;
    endtask
    task automatic wait_call(input logic [12:0] e);
        n = 0;
        while (vec_q.size() == 0 && n < 12) begin
            @(posedge clk_i);
            n++;
        end
        got = vec_q.size() ? vec_q.pop_front() : 13'h0;
        `CHK(got, e)
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(40920));
        repeat (5) @(posedge clk_i);
        rstn_i <= 1;
        // reset values, unmapped word, sparse masks, group flags
        for (int i = 0; i < 6; i++) rchk(8'(4 * i), 0);
        rchk(8'h28, 0);
        `CHK(er, 1'b1)
        for (int i = 0; i < 6; i++) begin
            apb(1, 8'(4 * i), 32'hFF);
            rchk(8'(4 * i), (i == 2 || i == 5) ? 32'h33 : 32'hFF);
        end
        rchk(OFF_FLAG, 32'h3F00);
        `CHK(wake, 1'b1)
        for (int i = 0; i < 6; i++) apb(1, 8'(4 * i), 0);
        apb(1, OFF_FLAG, 0);
        // let the last clear settle before looking at the wake level
        @(posedge clk_i);
        `CHK(wake, 1'b0)
        // event held off by a full stack, then serviced
        g = $urandom % 6;
        b = $urandom % 2;
        pulse(4 * g + b);
        rchk(8'(4 * g), 32'h10 << b);
        apb(1, 8'(4 * g), 32'h11 << b);
        apb(1, OFF_CTRL, (32'h100 << g) | 1);
        repeat (6) @(posedge clk_i);
        `CHK(ncall, 0)
        rchk(OFF_STAT, 32'h3);
        full <= 0;
        wait_call(13'(20 + 4 * g));
        rchk(8'(4 * g), 32'h11 << b);
        rchk(OFF_FLAG, 0);
        rchk(OFF_CTRL, 32'h100 << g);
        rchk(OFF_STAT, 32'h2 | ((4 + g) << 4));
        // request while blocked stays recorded and does not vector
        h = (g + 1) % 6;
        pulse(4 * h);
        apb(1, 8'(4 * h), 32'h11);
        apb(1, OFF_CTRL, (32'h100 << g) | (32'h100 << h));
        `CHK(ncall, 1)
        rchk(OFF_FLAG, 32'h100 << h);
        ret <= 1;
        @(posedge clk_i);
        ret <= 0;
        repeat (3) @(posedge clk_i);
        got = pc_q.pop_front();
        `CHK(resume, got)
        // pin 0 beats pending groups, then the lower group, slow core
        slow <= 1;
        apb(1, OFF_EDGE, 32'h1);
        apb(1, OFF_FLAG, 32'h1 | (32'h100 << g) | (32'h100 << h));
        apb(1, OFF_CTRL, 32'h11 | (32'h100 << g) | (32'h100 << h));
        wait_call(13'h4);
        rchk(OFF_FLAG, (32'h100 << g) | (32'h100 << h));
        apb(1, OFF_CTRL, 32'h11 | (32'h100 << g) | (32'h100 << h));
        wait_call(13'(20 + 4 * (g < h ? g : h)));
        // every edge code on a random pin
        slow <= 0;
        p = $urandom % 4;
        apb(1, OFF_CTRL, 32'hF0);
        for (int c = 0; c < 4; c++) begin
            apb(1, OFF_EDGE, c << (2 * p));
            apb(1, OFF_FLAG, 0);
            pin[p] <= 1;
            repeat (8) @(posedge clk_i);
            rchk(OFF_FLAG, (c & 1) << p);
            apb(1, OFF_FLAG, 0);
            pin[p] <= 0;
            repeat (8) @(posedge clk_i);
            rchk(OFF_FLAG, (c >> 1) << p);
        end
        // pin not routed as interrupt input: function off, then direction off
        apb(1, OFF_FLAG, 0);
        fsel[p] <= 0;
        pin[p] <= 1;
        repeat (8) @(posedge clk_i);
        dir[p] <= 0;
        fsel[p] <= 1;
        pin[p] <= 0;
        repeat (8) @(posedge clk_i);
        rchk(OFF_FLAG, 0);
        complete_run();
    end
endmodule
